// *** common/scsa_pkg.sv ***
// constants and types of the system clock sync and adjust block
`default_nettype none
// Overview of operation
// RULE1: under four seconds deviation time never goes backwards
// RULE2: selected pulse rising edge rounds time to minute
// RULE3: master holds each minute pulse at least 50 ms
// RULE4: pulse selector: off, DI1 to DI6, virtual
// RULE5: signed source offset added, range +-10000.000 s
// RULE6: sync updates source; silence 1.5 min gives internal
// RULE7: source reads internal after sync silence timeout
// RULE8: source codes: internal, pulse, SNTP, protocols
// RULE9: sixteen bit wrapping count of sync events
// RULE10: raw deviation reported in ms, clamped +-32767
// RULE11: filtered deviation applied and reported, clamped +-125
// RULE12: self-correct interval up to +-1000 s
// RULE13: drift sign lead or lag picks correction direction
// RULE14: external sync learns interval and sign, else settings
// RULE15: SNTP time gets zone offset in hundredths hours
// RULE16: daylight saving enable for SNTP time
// RULE17: editable settings written only after password unlock
// RULE18: configurer sets input debounce zero, leading edge
// RULE19: each interval shift time one ms against drift
// RULE20: filtered deviation corrected gradually, not stepped
// RULE21: millisecond counter, corrections skip or insert increments
package scsa_pkg;
  // ****************************************
  // timing
  // ****************************************
  localparam int  CLK_PERIOD_NS    = 8;
  localparam int  MS_NS            = 1000000;
  localparam int  CYC_PER_MS       = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam real FALLBACK_MIN     = 1.5;
  localparam int  FALLBACK_MS      = int'(FALLBACK_MIN * 60000.0);
  localparam int  STEP_LIMIT_S     = 4;
  localparam int  STEP_LIMIT_MS    = STEP_LIMIT_S * 1000;
  localparam int  MINUTE_MS        = 60000;
  localparam int  HALF_MINUTE_MS   = 30000;
  localparam int  ZONE_STEP_MS     = 36000;
  localparam int  DST_SHIFT_MS     = 3600000;
  localparam int  INTERVAL_UNIT_MS = 100;
  // ****************************************
  // value limits
  // ****************************************
  localparam int  DEV_LIMIT        = 32767;
  localparam int  FILT_LIMIT       = 125;
  localparam int  INTERVAL_MAX     = 10000;
  localparam int  OFFSET_LIMIT_MS  = 10000000;
  localparam int  ZONE_LIMIT       = 1500;
  // ****************************************
  // register offsets and fields
  // ****************************************
  localparam logic [3:0] REG_CTRL     = 4'h0;
  localparam logic [3:0] REG_OFFSET   = 4'h1;
  localparam logic [3:0] REG_INTERVAL = 4'h2;
  localparam logic [3:0] REG_ZONE     = 4'h3;
  localparam logic [3:0] REG_TIME_LO  = 4'h4;
  localparam logic [3:0] REG_TIME_HI  = 4'h5;
  localparam logic [3:0] REG_STATUS   = 4'h6;
  localparam logic [3:0] REG_DEV      = 4'h7;
  localparam logic [3:0] REG_UNLOCK   = 4'h8;
  localparam int CTRL_SEL_LSB  = 0;
  localparam int CTRL_LEAD_BIT = 4;
  localparam int CTRL_DST_BIT  = 5;
  localparam logic [3:0] RST_SELECT = 4'h0;
  // ****************************************
  // types
  // ****************************************
  typedef enum logic [3:0] {
    SRC_INTERNAL = 4'h0, SRC_PULSE = 4'h1, SRC_SNTP = 4'h2, SRC_SERIAL = 4'h3,
    SRC_MODBUS = 4'h4, SRC_MODBUS_TCP = 4'h5, SRC_IEC101 = 4'h6, SRC_IEC103 = 4'h7,
    SRC_DNP3 = 4'h8
  } scsa_src_e;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h1,
    ST_MEAS  = 3'h2,
    ST_APPLY = 3'h4
  } scsa_state_e;
endpackage
`default_nettype wire

// *** core/scsa_pulse_pick.sv ***
// minute pulse input synchroniser, selector and edge detector
`default_nettype none
module scsa_pulse_pick #(
  parameter int NUM_DI   = 6,
  parameter int NUM_VIRT = 4
) (
  input  wire logic                core_clk,  // system clock
  input  wire logic                rst,       // synchronous reset
  input  wire logic                ce,        // clock enable
  input  wire logic [NUM_DI-1:0]   diPin,     // digital input pins
  input  wire logic [NUM_VIRT-1:0] virtIn,    // virtual inputs, same clock
  input  wire logic [3:0]          select,    // pulse_input_select
  output logic                     pulseEdge  // one-cycle rising edge
);
  import scsa_pkg::*;

  logic [NUM_DI-1:0] syncA;
  logic [NUM_DI-1:0] syncB;
  logic [NUM_DI-1:0] syncC;
  logic [NUM_DI-1:0] diLevel;
  logic              selLevel;
  logic              prevLevel;
  logic [3:0]        prevSelect;

  // ****************************************
  // three stage synchronisers per pin
  // ****************************************
  for (genvar i = 0; i < NUM_DI; i++) begin : g_sync
    // level changes once second and third stage agree
    always_ff @(posedge core_clk) begin
      if (rst) begin
        syncA[i]   <= 1'b0;
        syncB[i]   <= 1'b0;
        syncC[i]   <= 1'b0;
        diLevel[i] <= 1'b0;
      end else if (ce) begin
        syncA[i] <= diPin[i];
        syncB[i] <= syncA[i];
        syncC[i] <= syncB[i];
        if (syncB[i] == syncC[i]) begin
          diLevel[i] <= syncC[i];
        end
      end
    end
  end

  // source mux: 0 off, then DI1.., then virtual inputs
  always_comb begin
    selLevel = 1'b0;
    if (select >= 4'h1 && 32'(select) <= NUM_DI) begin
      selLevel = diLevel[32'(select) - 1];  // [RULE4]
    end else if (32'(select) > NUM_DI && 32'(select) <= NUM_DI + NUM_VIRT) begin
      selLevel = virtIn[32'(select) - NUM_DI - 1];  // [RULE4]
    end
  end

  // rising edge, masked right after the selector moves
  always_ff @(posedge core_clk) begin
    if (rst) begin
      prevLevel  <= 1'b0;
      prevSelect <= RST_SELECT;
      pulseEdge  <= 1'b0;
    end else if (ce) begin
      prevLevel  <= selLevel;
      prevSelect <= select;
      pulseEdge  <= selLevel && !prevLevel && (select == prevSelect);
    end
  end
endmodule // scsa_pulse_pick
`default_nettype wire

// *** core/scsa_top.sv ***
// system clock keeping and sync adjust block
//
// The register addresses and strobed register access were decided locally.
`default_nettype none
module scsa_top #(
  parameter int          NUM_DI        = 6,
  parameter int          NUM_VIRT      = 4,
  parameter int          CYC_PER_MS_P  = scsa_pkg::CYC_PER_MS,
  parameter int          FALLBACK_MS_P = scsa_pkg::FALLBACK_MS,
  parameter logic [31:0] PASS_KEY      = 32'h5A5A_1234  // arbitrary value
) (
  input  wire logic                core_clk,     // 125 MHz clock
  input  wire logic                rst,          // synchronous reset
  input  wire logic                ce,           // clock enable
  input  wire logic [NUM_DI-1:0]   diPin,        // digital input pins
  input  wire logic [NUM_VIRT-1:0] virtIn,       // virtual inputs/outputs
  input  wire logic                msgValid,     // protocol time message strobe
  input  wire scsa_pkg::scsa_src_e msgSource,    // protocol of the message
  input  wire logic [39:0]         msgTime,      // message time in ms
  input  wire logic [3:0]          regAddr,      // register index
  input  wire logic [31:0]         regWdata,     // write data
  input  wire logic                regWr,        // write strobe
  input  wire logic                regRd,        // read strobe
  output logic [31:0]              regRdata,     // read data, cycle after
  output logic [39:0]              sysTimeMs,    // system time in ms
  output logic                     msTick,       // one-cycle ms tick
  output var scsa_pkg::scsa_src_e  activeSource  // active_time_source
);
  import scsa_pkg::*;

  localparam int TICK_W = $clog2(CYC_PER_MS_P + 1);
  localparam int SIL_W  = $clog2(FALLBACK_MS_P + 1);

  // ****************************************
  // declarations
  // ****************************************
  scsa_state_e          state;
  logic [TICK_W-1:0]    tickCnt;
  logic [39:0]          sysTime;
  logic [3:0]           pulseInputSelect;
  logic                 driftSign;
  logic                 dstEnable;
  logic signed [24:0]   sourceOffset;
  logic signed [15:0]   selfCorrectInterval;
  logic signed [11:0]   zoneOffsetHours;
  logic [31:0]          timeStage;
  logic                 unlocked;
  logic [15:0]          syncEventCount;
  logic signed [15:0]   deviation;
  logic signed [7:0]    filteredDeviation;
  logic signed [7:0]    slewPending;
  logic [SIL_W-1:0]     silenceMs;
  logic [31:0]          sinceSyncMs;
  logic [23:0]          autoMs;
  logic signed [41:0]   srcTime;
  logic signed [41:0]   devRaw;
  scsa_src_e            evtSource;
  logic                 pulseEdge;
  logic                 msgOk;
  logic                 wasSynced;
  logic                 take;
  logic                 wrOk;
  logic [16:0]          minuteRem;
  logic [39:0]          roundedMin;
  logic signed [28:0]   zoneProd;
  logic signed [41:0]   msgBase;
  logic signed [41:0]   devClamp;
  logic signed [41:0]   filtClamp;
  logic                 stepNow;
  logic [7:0]           absF;
  logic [31:0]          learnDiv;
  logic [31:0]          learnQ;
  logic [15:0]          autoMag;
  logic [23:0]          autoLimit;
  logic                 autoDue;
  logic                 effLead;
  logic [1:0]           incr;

  // clamp a signed value to +-lim
  function automatic logic signed [41:0] clampS(input logic signed [41:0] v, input int lim);
    logic signed [41:0] l;
    l = 42'(lim);
    if (v > l) return l;
    else if (v < -l) return -l;
    else return v;
  endfunction

  // ****************************************
  // pulse source
  // ****************************************
  scsa_pulse_pick #(
    .NUM_DI   (NUM_DI),
    .NUM_VIRT (NUM_VIRT)
  ) u_pick (
    .core_clk  (core_clk),
    .rst       (rst),
    .ce        (ce),
    .diPin     (diPin),
    .virtIn    (virtIn),
    .select    (pulseInputSelect),
    .pulseEdge (pulseEdge)
  );

  // ****************************************
  // source time and correction terms
  // ****************************************
  always_comb begin
    msgOk      = msgValid && (msgSource >= SRC_SNTP) && (msgSource <= SRC_DNP3);  // [RULE8]
    take       = ce && (state == ST_IDLE) && (pulseEdge || msgOk);
    minuteRem  = 17'(sysTime % 40'(MINUTE_MS));
    roundedMin = sysTime - 40'(minuteRem)
               + ((minuteRem >= 17'(HALF_MINUTE_MS)) ? 40'(MINUTE_MS) : 40'h0);  // [RULE2]
    zoneProd   = zoneOffsetHours * $signed(17'(ZONE_STEP_MS));
    msgBase    = $signed({2'h0, msgTime});
    if (msgSource == SRC_SNTP) begin
      msgBase = msgBase + 42'(zoneProd);  // [RULE15]
      if (dstEnable) msgBase = msgBase + 42'(DST_SHIFT_MS);  // [RULE16]
    end
    devClamp  = clampS(devRaw, DEV_LIMIT);  // [RULE10]
    filtClamp = clampS(devRaw >>> 1, FILT_LIMIT);  // [RULE11]
    stepNow   = (state == ST_APPLY) && ce
              && (devRaw >= 42'(STEP_LIMIT_MS) || devRaw <= -42'(STEP_LIMIT_MS));  // [RULE1]
    absF      = filtClamp[41] ? 8'(-filtClamp) : 8'(filtClamp);
    learnDiv  = 32'(absF) * 32'(INTERVAL_UNIT_MS);
    learnQ    = (learnDiv == 32'h0) ? 32'h0 : sinceSyncMs / learnDiv;
    autoMag   = selfCorrectInterval[15] ? 16'(-selfCorrectInterval)
                                        : 16'(selfCorrectInterval);
    autoLimit = 24'(autoMag) * 24'(INTERVAL_UNIT_MS);
    autoDue   = (selfCorrectInterval != 16'sh0) && (autoMs >= autoLimit);  // [RULE12]
    effLead   = driftSign ^ selfCorrectInterval[15];  // [RULE13]
    wrOk      = regWr && ce && unlocked;  // [RULE17]
  end

  // millisecond increment: 0 skips, 2 inserts, never negative
  always_comb begin
    incr = 2'h1;
    if (slewPending > 8'sh0) incr = 2'h2;  // [RULE20]
    else if (slewPending < 8'sh0) incr = 2'h0;  // [RULE1]
    else if (autoDue) incr = effLead ? 2'h0 : 2'h2;  // [RULE19]
  end

  // ****************************************
  // time base
  // ****************************************
  // cycle divider for the millisecond tick
  always_ff @(posedge core_clk) begin
    if (rst) begin
      tickCnt <= '0;
    end else if (ce) begin
      tickCnt <= (msTick) ? '0 : tickCnt + TICK_W'(1);
    end
  end
  assign msTick    = ce && (tickCnt == TICK_W'(CYC_PER_MS_P - 1));
  assign sysTimeMs = sysTime;

  // system time counter
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sysTime <= 40'h0;
    end else if (ce) begin
      if (wrOk && regAddr == REG_TIME_HI) sysTime <= {regWdata[7:0], timeStage};
      else if (stepNow) sysTime <= srcTime[41] ? 40'h0 : srcTime[39:0];
      else if (msTick) sysTime <= sysTime + 40'(incr);  // [RULE21]
    end
  end

  // ****************************************
  // sync sequence
  // ****************************************
  // capture source time, measure, apply
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state     <= ST_IDLE;
      srcTime   <= '0;
      devRaw    <= '0;
      evtSource <= SRC_INTERNAL;
    end else if (ce) begin
      case (state)
        ST_IDLE: begin
          if (pulseEdge) begin
            srcTime   <= $signed({2'h0, roundedMin}) + 42'(sourceOffset);  // [RULE5]
            evtSource <= SRC_PULSE;
            state     <= ST_MEAS;
          end else if (msgOk) begin
            srcTime   <= msgBase + 42'(sourceOffset);  // [RULE5]
            evtSource <= msgSource;
            state     <= ST_MEAS;
          end
        end
        ST_MEAS: begin
          devRaw <= $signed({2'h0, sysTime}) - srcTime;  // [RULE10]
          state  <= ST_APPLY;
        end
        ST_APPLY: state <= ST_IDLE;
        default:  state <= ST_IDLE;
      endcase
    end
  end

  // reported deviations and pending soft correction
  always_ff @(posedge core_clk) begin
    if (rst) begin
      deviation         <= 16'sh0;
      filteredDeviation <= 8'sh0;
      slewPending       <= 8'sh0;
    end else if (ce) begin
      if (state == ST_APPLY) begin
        deviation         <= devClamp[15:0];  // [RULE10]
        filteredDeviation <= stepNow ? 8'sh0 : filtClamp[7:0];  // [RULE11]
        slewPending       <= stepNow ? 8'sh0 : 8'(-filtClamp);  // [RULE20]
      end else if (msTick && slewPending > 8'sh0) begin
        slewPending <= slewPending - 8'sh1;
      end else if (msTick && slewPending < 8'sh0) begin
        slewPending <= slewPending + 8'sh1;
      end
    end
  end

  // event count, source report and silence fallback
  always_ff @(posedge core_clk) begin
    if (rst) begin
      syncEventCount <= 16'h0;
      activeSource   <= SRC_INTERNAL;
      silenceMs      <= '0;
      sinceSyncMs    <= 32'h0;
      wasSynced      <= 1'b0;
    end else if (ce) begin
      if (take) begin
        syncEventCount <= syncEventCount + 16'h1;  // [RULE9]
        activeSource   <= pulseEdge ? SRC_PULSE : msgSource;  // [RULE6]
        silenceMs      <= '0;
        wasSynced      <= (activeSource != SRC_INTERNAL);  // [RULE14]
      end else if (msTick) begin
        if (silenceMs == SIL_W'(FALLBACK_MS_P)) begin
          activeSource <= SRC_INTERNAL;  // [RULE6] [RULE7]
        end else begin
          silenceMs <= silenceMs + SIL_W'(1);
        end
      end
      // span since the last applied sync, cleared only after learning read it
      if (state == ST_APPLY) sinceSyncMs <= 32'h0;
      else if (msTick && sinceSyncMs != 32'hFFFF_FFFF) sinceSyncMs <= sinceSyncMs + 32'h1;
    end
  end

  // interval counter for periodic one ms corrections
  always_ff @(posedge core_clk) begin
    if (rst) begin
      autoMs <= 24'h0;
    end else if (ce) begin
      if (selfCorrectInterval == 16'sh0) autoMs <= 24'h0;
      else if (msTick && autoDue && slewPending == 8'sh0) autoMs <= 24'h0;  // [RULE19]
      else if (msTick && !autoDue) autoMs <= autoMs + 24'h1;
    end
  end

  // ****************************************
  // settings registers
  // ****************************************
  // software writes when unlocked; learning while synced
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pulseInputSelect    <= RST_SELECT;
      driftSign           <= 1'b0;
      dstEnable           <= 1'b0;
      sourceOffset        <= 25'sh0;
      selfCorrectInterval <= 16'sh0;
      zoneOffsetHours     <= 12'sh0;
      timeStage           <= 32'h0;
      unlocked            <= 1'b0;
    end else if (ce) begin
      if (regWr && regAddr == REG_UNLOCK) unlocked <= (regWdata == PASS_KEY);  // [RULE17]
      if (wrOk) begin
        case (regAddr)
          REG_CTRL: begin
            pulseInputSelect <= regWdata[CTRL_SEL_LSB +: 4];  // [RULE4]
            driftSign        <= regWdata[CTRL_LEAD_BIT];  // [RULE13]
            dstEnable        <= regWdata[CTRL_DST_BIT];  // [RULE16]
          end
          REG_OFFSET:   sourceOffset <= 25'(clampS(42'($signed(regWdata)), OFFSET_LIMIT_MS));
          REG_INTERVAL: selfCorrectInterval <= 16'(clampS(42'($signed(regWdata)), INTERVAL_MAX));
          REG_ZONE:     zoneOffsetHours <= 12'(clampS(42'($signed(regWdata)), ZONE_LIMIT));
          REG_TIME_LO:  timeStage <= regWdata;
          default: ;
        endcase
      end else if (state == ST_APPLY && !stepNow && absF != 8'h0
                   && wasSynced) begin
        driftSign           <= !filtClamp[41];  // [RULE14]
        selfCorrectInterval <= (learnQ > 32'(INTERVAL_MAX)) ? 16'(INTERVAL_MAX)
                                                            : learnQ[15:0];  // [RULE14]
      end
    end
  end

  // ****************************************
  // read port
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (rst) begin
      regRdata <= 32'h0;
    end else if (ce) begin
      regRdata <= 32'h0;
      if (regRd) begin
        case (regAddr)
          REG_CTRL:     regRdata <= {26'h0, dstEnable, driftSign, pulseInputSelect};
          REG_OFFSET:   regRdata <= 32'(sourceOffset);
          REG_INTERVAL: regRdata <= 32'(selfCorrectInterval);
          REG_ZONE:     regRdata <= 32'(zoneOffsetHours);
          REG_TIME_LO:  regRdata <= sysTime[31:0];
          REG_TIME_HI:  regRdata <= {24'h0, sysTime[39:32]};
          REG_STATUS:   regRdata <= {syncEventCount, 12'h0, activeSource};
          REG_DEV:      regRdata <= {16'(filteredDeviation), deviation};
          REG_UNLOCK:   regRdata <= {31'h0, unlocked};
          default:      regRdata <= 32'h0;
        endcase
      end
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence s_taken;
    take;
  endsequence
  sequence s_pulseTaken;
    take && pulseEdge;
  endsequence

  property p_noBackwards;
    ce && !stepNow && !(wrOk && regAddr == REG_TIME_HI) |=> sysTime >= $past(sysTime);
  endproperty
  a_noBackwards: assert property (p_noBackwards) else $error("time went back"); // [RULE1]

  property p_roundMinute;
    s_pulseTaken |=> ((srcTime - 42'(sourceOffset)) % 42'sd60000) == 42'sd0;
  endproperty
  a_roundMinute: assert property (p_roundMinute) else $error("pulse not minute"); // [RULE2]

  property p_count;
    s_taken |=> syncEventCount == $past(syncEventCount) + 16'h1;
  endproperty
  a_count: assert property (p_count) else $error("event count wrong"); // [RULE9]

  property p_devClamp;
    ce && state == ST_APPLY && devRaw > 42'sd32767 |=> deviation == 16'sd32767;
  endproperty
  a_devClamp: assert property (p_devClamp) else $error("deviation not clamped"); // [RULE10]

  property p_filtRange;
    s_taken ##2 ce |=> filteredDeviation <= 8'sd125 && filteredDeviation >= -8'sd125;
  endproperty
  a_filtRange: assert property (p_filtRange) else $error("filtered out of range"); // [RULE11]

  property p_fallback;
    msTick && !take && silenceMs == SIL_W'(FALLBACK_MS_P) |=> activeSource == SRC_INTERNAL;
  endproperty
  a_fallback: assert property (p_fallback) else $error("no fallback"); // [RULE6]

  property p_locked;
    ce && regWr && !unlocked && regAddr == REG_ZONE |=> $stable(zoneOffsetHours);
  endproperty
  a_locked: assert property (p_locked) else $error("locked write took"); // [RULE17]

  property p_skip;
    msTick && slewPending < 8'sh0 && !stepNow && !wrOk |=> $stable(sysTime);
  endproperty
  a_skip: assert property (p_skip) else $error("skip not applied"); // [RULE20]
endmodule // scsa_top
`default_nettype wire

// *** test/scsa_time_master.sv ***
// time master model: minute pulse and protocol time messages
`default_nettype none
module scsa_time_master #(
  parameter int HOLD_CYC = 600  // pulse high time in cycles
) (
  input  wire logic               core_clk,   // clock
  input  wire logic               firePulse,  // start one pulse
  input  wire logic               fireMsg,    // send one message
  input  wire logic [3:0]         code,       // message protocol
  input  wire logic [39:0]        stamp,      // message time in ms
  output logic                    pin,        // minute pulse pin
  output logic                    msgValid,   // message strobe
  output var scsa_pkg::scsa_src_e msgSource,  // message protocol
  output logic [39:0]             msgTime     // message time
);
  timeunit 1ns;
  timeprecision 1ps;
  import scsa_pkg::*;
  int held = 0;
  // pulse held long, rising edge is the sync edge
  always @(posedge core_clk) begin
    held <= firePulse ? HOLD_CYC : (held > 0 ? held - 1 : 0);
  end
  assign pin = held > 0;
  // one-cycle message, fields scrambled outside it
  always @(posedge core_clk) begin
    msgValid  <= fireMsg;
    msgSource <= fireMsg ? scsa_src_e'(code) : scsa_src_e'(~code);
    msgTime   <= fireMsg ? stamp : ~stamp;
  end
endmodule // scsa_time_master
`default_nettype wire

// *** test/tb_system_clock_sync_adjust.sv ***
// self-checking bench of the clock sync and adjust block
`default_nettype none
module tb_system_clock_sync_adjust;
  timeunit 1ns;
  timeprecision 1ps;
  import scsa_pkg::*;
  localparam logic [31:0] KEY = 32'h5A5A_1234;  // arbitrary value
  logic        core_clk, rst, regWr, regRd, msTick, pin, msgValid, firePulse, fireMsg;
  logic [3:0]  regAddr, code;
  logic [31:0] regWdata, regRdata, d;
  logic [39:0] sysTimeMs, msgTime, stamp, t0, t1;
  scsa_src_e   activeSource, msgSource;
  int          errTotal = 0, numChecks = 0, n;
  scsa_top #(.CYC_PER_MS_P(10), .FALLBACK_MS_P(20), .PASS_KEY(KEY)) uut (
    .core_clk(core_clk), .rst(rst), .ce(1'b1), .diPin({5'h00, pin}), .virtIn(4'h0),
    .msgValid(msgValid), .msgSource(msgSource), .msgTime(msgTime), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .sysTimeMs(sysTimeMs), .msTick(msTick), .activeSource(activeSource));
  scsa_time_master #(.HOLD_CYC(600)) master (
    .core_clk(core_clk), .firePulse(firePulse), .fireMsg(fireMsg), .code(code),
    .stamp(stamp), .pin(pin), .msgValid(msgValid), .msgSource(msgSource),
    .msgTime(msgTime));
  // ****************************************
  // helpers
  // ****************************************
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  task automatic chk(input string nm, input logic [39:0] e, input logic [39:0] g);
    numChecks++;
    if (g !== e) begin
      errTotal++;
      $display("[ERR] %s exp %0h got %0h", nm, e, g);
    end
  endtask
  task automatic close_out;
    if (errTotal == 0 && numChecks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    regAddr <= a; regWdata <= v; regWr <= 1'b1;
    @(posedge core_clk); regWr <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    regAddr <= a; regRd <= 1'b1;
    @(posedge core_clk); regRd <= 1'b0;
    #1 v = regRdata;
    @(posedge core_clk);
  endtask
  task automatic send(input logic [3:0] c, input logic [39:0] t);
    code <= c; stamp <= t; fireMsg <= 1'b1;
    @(posedge core_clk); fireMsg <= 1'b0;
    repeat (8) @(posedge core_clk);
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_lock;
    rd(REG_STATUS, d); chk("status", 0, d);
    wr(REG_CTRL, 32'h1); rd(REG_CTRL, d); chk("locked", 0, d[3:0]);
    wr(REG_UNLOCK, KEY); wr(REG_CTRL, 32'h1); rd(REG_CTRL, d);
    chk("select", 1, d[3:0]);
    rd(4'h9, d); chk("unmapped", 0, d);
  endtask
  task automatic t_drift;
    wr(REG_INTERVAL, 32'h1); wr(REG_CTRL, 32'h10);
    t0 = sysTimeMs; n = 0;
    repeat (10000) begin
      @(posedge core_clk); #1; n += msTick;
    end
    chk("ticks", 1000, n);
    chk("drift", 1, (sysTimeMs - t0) inside {[989:991]});
    @(posedge core_clk);
    wr(REG_INTERVAL, 32'h0);
  endtask
  task automatic t_msgs;
    for (int c = 2; c <= 8; c++) begin
      send(c[3:0], sysTimeMs);
      chk("source", c, activeSource);
      rd(REG_STATUS, d); chk("count", c - 1, d[31:16]);
    end
    send(4'h9, sysTimeMs); rd(REG_STATUS, d); chk("bad code", 7, d[31:16]);
    repeat (130) @(posedge core_clk); chk("held", SRC_DNP3, activeSource);
    repeat (100) @(posedge core_clk); chk("fallback", SRC_INTERNAL, activeSource);
  endtask
  task automatic t_pulse;
    wr(REG_CTRL, 32'h1); wr(REG_TIME_LO, 32'd50000); wr(REG_TIME_HI, 32'h0);
    firePulse <= 1'b1; @(posedge core_clk); firePulse <= 1'b0;
    repeat (20) @(posedge core_clk);
    chk("minute", 1, (sysTimeMs - 40'd60000) <= 40'd3);
    chk("pulse src", SRC_PULSE, activeSource);
    repeat (700) @(posedge core_clk);
  endtask
  task automatic t_slew;
    t0 = sysTimeMs;
    send(4'h2, sysTimeMs - 40'd1000); rd(REG_DEV, d);
    chk("filtered", 125, d[31:16]);
    chk("deviation", 1, d[15:0] inside {[998:1002]});
    t1 = sysTimeMs;
    for (int i = 0; i < 2000; i++) begin
      t0 = sysTimeMs; @(posedge core_clk); #1;
      if (sysTimeMs < t0) chk("backwards", t0, sysTimeMs);
    end
    chk("slowed", 1, (sysTimeMs - t1) inside {[74:77]});
    t0 = sysTimeMs; repeat (1000) @(posedge core_clk);
    chk("resumed", 1, (sysTimeMs - t0) inside {[99:101]});
  endtask
  // ****************************************
  // main sequence and watchdog
  // ****************************************
  initial begin
    rst = 1'b1; regWr = 1'b0; regRd = 1'b0; regAddr = 4'h0; regWdata = 32'h0;
    firePulse = 1'b0; fireMsg = 1'b0; code = 4'h0; stamp = 40'h0;
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    t_lock; t_drift; t_msgs; t_pulse; t_slew;
    close_out;
  end
  initial begin
    repeat (40000) @(posedge core_clk);
    errTotal++;
    close_out;
  end
endmodule // tb_system_clock_sync_adjust
`default_nettype wire
